//--- msi_assertions.sv
// protocol checker for the start-up message link
`timescale 1ns/10ps
module msi_assertions #(
   parameter int INIT_CYC = 20
) (
   // clock and reset
   input wire logic        clk_in,
   input wire logic        rst_in,
   // link signals
   input wire logic        msg_valid,
   input wire logic [31:0] msg_word,
   input wire logic [7:0]  count,
   input wire logic [7:0]  lock,
   input wire logic        inc_req,
   input wire logic        rel_req,
   input wire logic        acq_req,
   input wire logic        acq_gnt
);
   localparam int INIT_LO = INIT_CYC;
   localparam int INIT_HI = INIT_CYC + 2;
   // message kind decode
   wire logic is_init = msg_valid && msg_word == msi_pkg::CMD_INIT_ALL;
   wire logic is_start = msg_valid && (msg_word & msi_pkg::CMD_TYPE_MASK)
                         == msi_pkg::CMD_STARTUP_ALL;
   logic seen_q;
   // marks the first start-up message
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) seen_q <= 1'b0;
      else if (is_start) seen_q <= 1'b1;
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   property p_kind; msg_valid |-> is_init || is_start; endproperty
   a_kind: assert property (p_kind)
      else $error("unknown command word");
   property p_init_quiet; is_init |=> !msg_valid [*8]; endproperty
   a_init_quiet: assert property (p_init_quiet)
      else $error("message too soon after init");
   property p_init_start; is_init |-> ##[INIT_LO:INIT_HI] is_start;
   endproperty
   a_init_start: assert property (p_init_start)
      else $error("start-up not sent after init wait");
   property p_gap; is_start && !seen_q |=> !msg_valid [*4]; endproperty
   a_gap: assert property (p_gap)
      else $error("second start-up too soon");
   property p_preset; is_init |-> count == msi_pkg::COUNT_PRESET
      && lock == msi_pkg::FREE_LOCK_VALUE; endproperty
   a_preset: assert property (p_preset)
      else $error("counter or lock not preset");
   property p_grant; acq_gnt |-> acq_req
      && lock == msi_pkg::FREE_LOCK_VALUE; endproperty
   a_grant: assert property (p_grant)
      else $error("grant without free lock");
   property p_held; acq_gnt |=> lock == msi_pkg::HELD_LOCK_VALUE;
   endproperty
   a_held: assert property (p_held)
      else $error("lock not taken after grant");
   property p_order; acq_gnt |=> inc_req ##1 rel_req; endproperty
   a_order: assert property (p_order)
      else $error("init order broken");
   property p_inc; inc_req |=> count == $past(count) + 8'h01; endproperty
   a_inc: assert property (p_inc)
      else $error("counter not raised by one");
   property p_only; $changed(count) |-> $past(inc_req); endproperty
   a_only: assert property (p_only)
      else $error("counter changed without request");
endmodule : msi_assertions

//--- msi_bench.sv
// bench: boot end facing one secondary end
`timescale 1ns/10ps
module msi_bench;
   logic        clk_in = 1'b0;
   logic        rst_in = 1'b1;
   logic        start = 1'b0;
   logic        is_boot = 1'b0;
   logic        svr_we = 1'b0;
   logic        err_we = 1'b0;
   logic        mwait = 1'b1;
   logic        ce = 1'b1;
   logic [7:0]  pid = 8'h5a;
   logic [7:0]  vec = 8'h00;
   logic [7:0]  expct = 8'h00;
   logic [7:0]  err_vec = 8'h00;
   logic [31:0] svr_wd = 32'h00000000;
   logic        busy, done, none, fv, en, bflag, halt, sleep;
   logic [7:0]  count;
   logic [31:0] faddr, spurious_vector_register, err, id_reg;
   int          fail_count = 0;
   int          checks = 0;
   int          fetch_n = 0;
   int          n_unk, n_known;
   msi_link_if link ();
   msi_boot #(.INIT_CYC(20), .GAP_CYC(5), .REPORT_CYC(50)) msi_boot_i (
      .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .link(link.boot),
      .start_in(start), .page_vec_in(vec), .expected_in(expct),
      .busy_out(busy), .done_out(done), .none_found_out(none),
      .count_out(count));
   msi_secondary msi_secondary_i (
      .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .link(link.secondary),
      .is_boot_in(is_boot), .proc_id_in(pid), .svr_we_in(svr_we),
      .svr_wdata_in(svr_wd), .err_we_in(err_we), .err_vec_in(err_vec),
      .mwait_ok_in(mwait), .fetch_valid_out(fv), .fetch_addr_out(faddr),
      .svr_out(spurious_vector_register), .err_entry_out(err), .id_reg_out(id_reg),
      .enabled_out(en), .boot_flag_out(bflag), .halted_out(halt),
      .deep_sleep_out(sleep));
   msi_assertions #(.INIT_CYC(20)) msi_assertions_i (
      .clk_in(clk_in), .rst_in(rst_in), .msg_valid(link.msg_valid),
      .msg_word(link.msg_word), .count(link.count), .lock(link.lock),
      .inc_req(link.inc_req), .rel_req(link.rel_req),
      .acq_req(link.acq_req), .acq_gnt(link.acq_gnt));
   // clock and fetch pulse counter
   initial forever #5 clk_in = ~clk_in;
   always @(posedge clk_in) if (fv === 1'b1) fetch_n++;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic do_reset(input logic boot);
      is_boot <= boot;
      rst_in <= 1'b1;
      repeat (6) @(posedge clk_in);
      fetch_n = 0;
      rst_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      #1;
   endtask : do_reset
   task automatic run_seq(input logic [7:0] exp_n, output int n);
      @(posedge clk_in);
      vec <= 8'hbd;
      expct <= exp_n;
      start <= 1'b1;
      @(posedge clk_in);
      start <= 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 400) begin
         @(posedge clk_in);
         n++;
      end
      #1;
      check(done, 1'b1);
   endtask : run_seq
   task automatic t_regs();
      do_reset(1'b0);
      check(spurious_vector_register, msi_pkg::SVR_RESET);
      check(en, 1'b0);
      check(err, msi_pkg::ERR_RESET);
      check(id_reg & msi_pkg::ID_MASK, 32'h5a000000);
      check({bflag, halt, fetch_n[0]}, 3'h0);
      @(posedge clk_in);
      ce <= 1'b0;
      svr_we <= 1'b1;
      svr_wd <= msi_pkg::SVR_RESET | 32'h00000100;
      err_we <= 1'b1;
      err_vec <= 8'hc3;
      @(posedge clk_in);
      @(posedge clk_in);
      #1;
      check(en, 1'b0);
      @(posedge clk_in);
      ce <= 1'b1;
      @(posedge clk_in);
      svr_we <= 1'b0;
      err_we <= 1'b0;
      @(posedge clk_in);
      #1;
      check(en, 1'b1);
      check(err, {msi_pkg::ERR_RESET[31:8], 8'hc3});
      $display("test regs done");
   endtask : t_regs
   task automatic t_wake(input logic [7:0] exp_n, output int n);
      do_reset(1'b0);
      run_seq(exp_n, n);
      check(fetch_n, 1);
      check(faddr, 32'h000bd000);
      check(count, 8'h02);
      check({none, sleep}, {1'b0, mwait});
      $display("test wake done");
   endtask : t_wake
   task automatic t_none();
      do_reset(1'b1);
      check({bflag, faddr}, {1'b1, msi_pkg::RESET_FETCH});
      run_seq(8'h00, n_unk);
      check({none, count}, 9'h101);
      check(fetch_n, 1);
      $display("test none done");
   endtask : t_none
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_of_test
   // watchdog against a hung sequence
   initial begin
      #40000;
      fail_count++;
      end_of_test();
   end
   initial begin
      t_regs();
      t_wake(8'h00, n_unk);
      t_wake(8'h02, n_known);
      check(n_known < n_unk, 1'b1);
      t_none();
      end_of_test();
   end
endmodule : msi_bench

//--- msi_boot.sv
// boot processor end: start-up sequencer, shared counter and lock
`timescale 1ns/10ps
//
// Contract
// [R1] secondary starts fetch at message vector address
// [R2] vector V maps to V shifted by twelve
// [R3] controller enabled by bit eight, reset zero
// [R4] error entry vector in low byte
// [R5] identifier in top byte, boot default zero; code takes top byte from proc_id_in, BOOT_ID_DEFAULT unused
// [R6] broadcast init uses 000C4500
// [R7] broadcast start-up uses 000C46 plus vector
// [R8] wait ten milliseconds after init
// [R9] second start-up after 200 microseconds
// [R10] wait 100 ms, unchanged count means none
// [R11] stop early when expected count reached
// [R12] counter preset one, each secondary adds one
// [R13] lock preset free, secondaries take in turn
// [R14] controller range mapped strong uncached
// [R15] each processor distinct save area base
// [R16] secondary halts or sleeps until init
// [R17] boot processor fetches at reset address
// [R18] start-up code in one page below 1MB
// [R19] non-boot processors wait for start-up message
// [R20] late start-up message is ignored
module msi_boot #(
   parameter int INIT_CYC   = msi_pkg::INIT_WAIT_CYC,
   parameter int GAP_CYC    = msi_pkg::STARTUP_GAP_CYC,
   parameter int REPORT_CYC = msi_pkg::REPORT_WAIT_CYC
) (
   // clock, reset, enable
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       ce_in,
   // link
   msi_link_if.boot        link,
   // software side
   input  wire logic       start_in,
   input  wire logic [7:0] page_vec_in,
   input  wire logic [7:0] expected_in,
   output logic            busy_out,
   output logic            done_out,
   output logic            none_found_out,
   output logic [7:0]      count_out
);
   typedef enum logic [2:0] {B_IDLE, B_INIT, B_SIPI1, B_SIPI2,
                             B_REPORT, B_DONE} msi_boot_e;
   msi_boot_e   st_q;
   logic [31:0] tmr_q;
   logic [7:0]  cnt_q, lock_q, vec_q;
   logic        mv_q, nf_q;
   logic [31:0] mw_q;

   function automatic logic [31:0] msi_cyc(input int n);
      msi_cyc = 32'(n);
   endfunction : msi_cyc

   // lock grant: free value and request wins in one cycle
   wire grant    = link.acq_req && (lock_q == msi_pkg::FREE_LOCK_VALUE);
   wire tmr_done = (tmr_q == 32'h00000000);
   wire reached  = (expected_in != 8'h00) && (cnt_q >= expected_in); // R11

   assign link.acq_gnt   = ce_in && grant; // R13
   assign link.msg_valid = mv_q;
   assign link.msg_word  = mw_q;
   assign link.count     = cnt_q;
   assign link.lock      = lock_q;

   // sequencer and shared memory
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_q   <= B_IDLE;
         tmr_q  <= 32'h00000000;
         cnt_q  <= msi_pkg::COUNT_PRESET; // R12
         lock_q <= msi_pkg::FREE_LOCK_VALUE; // R13
         vec_q  <= 8'h00;
         mv_q   <= 1'b0;
         mw_q   <= 32'h00000000;
         nf_q   <= 1'b0;
      end else if (ce_in) begin
         mv_q <= 1'b0;
         if (link.inc_req)
            cnt_q <= cnt_q + 8'h01; // R12
         if (grant)
            lock_q <= msi_pkg::HELD_LOCK_VALUE; // R13
         else if (link.rel_req)
            lock_q <= msi_pkg::FREE_LOCK_VALUE; // R13
         if (!tmr_done)
            tmr_q <= tmr_q - 32'h00000001;
         case (st_q)
            B_IDLE: if (start_in) begin
               cnt_q  <= msi_pkg::COUNT_PRESET; // R12
               lock_q <= msi_pkg::FREE_LOCK_VALUE; // R13
               vec_q  <= page_vec_in; // R18
               nf_q   <= 1'b0;
               mv_q   <= 1'b1;
               mw_q   <= msi_pkg::CMD_INIT_ALL; // R6
               tmr_q  <= msi_cyc(INIT_CYC); // R8
               st_q   <= B_INIT;
            end
            B_INIT: if (tmr_done) begin
               mv_q  <= 1'b1;
               mw_q  <= msi_pkg::CMD_STARTUP_ALL | {24'h000000, vec_q}; // R7
               tmr_q <= msi_cyc(GAP_CYC); // R9
               st_q  <= B_SIPI1;
            end
            B_SIPI1: if (tmr_done) begin
               mv_q  <= 1'b1; // R9
               tmr_q <= msi_cyc(REPORT_CYC); // R10
               st_q  <= B_SIPI2;
            end
            B_SIPI2: st_q <= B_REPORT;
            B_REPORT: if (reached) begin
               st_q <= B_DONE; // R11
            end else if (tmr_done) begin
               nf_q <= (cnt_q == msi_pkg::COUNT_PRESET); // R10
               st_q <= B_DONE;
            end
            B_DONE: if (start_in) st_q <= B_IDLE;
            default: st_q <= B_IDLE;
         endcase
      end
   end

   assign busy_out       = (st_q != B_IDLE) && (st_q != B_DONE);
   assign done_out       = (st_q == B_DONE);
   assign none_found_out = nf_q;
   assign count_out      = cnt_q;
endmodule : msi_boot

//--- msi_link_if.sv
// link between boot processor end and secondary processor end
`timescale 1ns/10ps
interface msi_link_if;
   logic        msg_valid;  // one-cycle command word strobe
   logic [31:0] msg_word;   // command word low
   logic [7:0]  count;      // shared processor counter
   logic [7:0]  lock;       // shared lock value
   logic        inc_req;    // secondary adds one to counter
   logic        acq_req;    // secondary requests the lock
   logic        rel_req;    // secondary frees the lock
   logic        acq_gnt;    // lock granted this cycle
   modport boot (output msg_valid, msg_word, count, lock, acq_gnt,
                 input inc_req, acq_req, rel_req);
   modport secondary (input msg_valid, msg_word, count, lock, acq_gnt,
                      output inc_req, acq_req, rel_req);
endinterface : msi_link_if

//--- msi_pkg.sv
// shared constants for the multiprocessor start-up message link
package msi_pkg;
   // command word encodings and fields
   localparam logic [31:0] CMD_INIT_ALL    = 32'h000c4500;
   localparam logic [31:0] CMD_STARTUP_ALL = 32'h000c4600;
   localparam logic [31:0] CMD_TYPE_MASK   = 32'hffffff00;
   localparam int          VEC_LSB         = 0;
   localparam int          VEC_W           = 8;
   localparam int          PAGE_SHIFT      = 12;
   // register layout
   localparam int          SVR_ENABLE_BIT  = 8;
   localparam logic [31:0] ID_MASK         = 32'hff000000;
   localparam int          ID_LSB          = 24;
   localparam logic [31:0] SVR_RESET       = 32'h000000ff;
   localparam logic [31:0] ERR_RESET       = 32'h00010000;
   localparam logic [7:0]  BOOT_ID_DEFAULT = 8'h00;
   // shared memory values
   localparam logic [7:0]  FREE_LOCK_VALUE = 8'h00;
   localparam logic [7:0]  HELD_LOCK_VALUE = 8'hff;
   localparam logic [7:0]  COUNT_PRESET    = 8'h01;
   // addresses
   localparam logic [31:0] RESET_FETCH     = 32'hfffffff0;
   // timing in own units and as 100 MHz cycle counts
   localparam int          CLK_MHZ         = 100;
   localparam int          INIT_WAIT_MS    = 10;
   localparam int          STARTUP_GAP_US  = 200;
   localparam int          REPORT_WAIT_MS  = 100;
   localparam int INIT_WAIT_CYC   = INIT_WAIT_MS * 1000 * CLK_MHZ;
   localparam int STARTUP_GAP_CYC = STARTUP_GAP_US * CLK_MHZ;
   localparam int REPORT_WAIT_CYC = REPORT_WAIT_MS * 1000 * CLK_MHZ;
endpackage : msi_pkg

//--- msi_secondary.sv
// secondary processor end: start-up message receiver and init sequence
`timescale 1ns/10ps
module msi_secondary (
   // clock, reset, enable
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        ce_in,
   // link
   msi_link_if.secondary    link,
   // processor side
   input  wire logic        is_boot_in,
   input  wire logic [7:0]  proc_id_in,
   input  wire logic        svr_we_in,
   input  wire logic [31:0] svr_wdata_in,
   input  wire logic        err_we_in,
   input  wire logic [7:0]  err_vec_in,
   input  wire logic        mwait_ok_in,
   output logic             fetch_valid_out,
   output logic [31:0]      fetch_addr_out,
   output logic [31:0]      svr_out,
   output logic [31:0]      err_entry_out,
   output logic [31:0]      id_reg_out,
   output logic             enabled_out,
   output logic             boot_flag_out,
   output logic             halted_out,
   output logic             deep_sleep_out
);
   typedef enum logic [2:0] {ST_BOOT, ST_WAIT, ST_LOCK, ST_INIT,
                             ST_REL, ST_HALT} msi_sec_e;
   msi_sec_e    st_q, st_d;
   logic [31:0] svr_q, err_q, addr_q;
   logic        fv_q, bf_q, ds_q, strap_q;

   // message decode
   wire is_startup = link.msg_valid && ((link.msg_word &
        msi_pkg::CMD_TYPE_MASK) == msi_pkg::CMD_STARTUP_ALL);
   wire is_init = link.msg_valid && (link.msg_word == msi_pkg::CMD_INIT_ALL);
   wire [7:0] vec = link.msg_word[msi_pkg::VEC_LSB +: msi_pkg::VEC_W];
   wire [31:0] page_addr = {12'h000, vec, 12'h000}; // R2

   assign link.acq_req = (st_q == ST_LOCK); // R13
   assign link.inc_req = ce_in && (st_q == ST_INIT); // R12
   assign link.rel_req = ce_in && (st_q == ST_REL); // R13

   // next state
   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_BOOT: st_d = ST_BOOT;
         ST_WAIT: if (is_startup) st_d = ST_LOCK; // R1 R19
         ST_LOCK: if (link.acq_gnt) st_d = ST_INIT; // R13
         ST_INIT: st_d = ST_REL;
         ST_REL:  st_d = ST_HALT; // R16
         ST_HALT: if (is_init) st_d = ST_WAIT; // R16 R20
         default: st_d = ST_WAIT;
      endcase
   end

   // state and registers
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_q    <= ST_WAIT;
         strap_q <= 1'b0;
         svr_q   <= msi_pkg::SVR_RESET; // R3
         err_q   <= msi_pkg::ERR_RESET;
         addr_q  <= 32'h00000000;
         fv_q    <= 1'b0;
         bf_q    <= 1'b0;
         ds_q    <= 1'b0;
      end else if (ce_in) begin
         fv_q <= 1'b0;
         if (!strap_q) begin
            strap_q <= 1'b1;
            bf_q    <= is_boot_in; // R19
            if (is_boot_in) begin
               st_q   <= ST_BOOT;
               addr_q <= msi_pkg::RESET_FETCH; // R17
               fv_q   <= 1'b1;
            end
         end else begin
            st_q <= st_d;
            if (st_q == ST_WAIT && is_startup) begin
               addr_q <= page_addr; // R1
               fv_q   <= 1'b1;
            end
            if (st_q == ST_REL)
               ds_q <= mwait_ok_in; // R16
         end
         if (svr_we_in)
            svr_q <= svr_wdata_in; // R3
         if (err_we_in)
            err_q[7:0] <= err_vec_in; // R4
      end
   end

   assign fetch_valid_out = fv_q;
   assign fetch_addr_out  = addr_q;
   assign svr_out         = svr_q;
   assign err_entry_out   = err_q;
   assign enabled_out     = svr_q[msi_pkg::SVR_ENABLE_BIT]; // R3
   assign id_reg_out      = {proc_id_in, 24'h000000} & msi_pkg::ID_MASK; // R5
   assign boot_flag_out   = bf_q;
   assign halted_out      = (st_q == ST_HALT);
   assign deep_sleep_out  = (st_q == ST_HALT) && ds_q;
endmodule : msi_secondary
